// ---- hdl/adcc_conversion_control.sv ----
// converter control: apb registers, bit clock, conversion sequencer, result store
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "adcc_defines.svh"
`default_nettype none
module adcc_conversion_control
    import adcc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sleep_req,
    input  wire logic        rc_clk_in,
    input  wire logic        cmp_high,
    output logic      [4:0]  chan_sel,
    output logic             sample_en,
    output logic      [11:0] sar_code,
    output logic             conv_power,
    output logic             conv_irq,
    output logic             wake_req
);

    // software registers
    logic        en_q;
    logic        go_q;
    logic [3:0]  chs_lo_q;
    logic [1:0]  div_sel_q;
    logic        rc_sel_q;
    logic        chs4_q;
    logic        align_q;
    logic        flag_q;
    logic        irq_en_q;
    logic [7:0]  res_high_q;
    logic [7:0]  res_low_q;
    // sequencer state
    adcc_state_t state_q;
    logic [4:0]  tad_cnt_q;
    logic [7:0]  div_cnt_q;
    logic        tad_tick_q;
    logic [7:0]  dly_cnt_q;
    logic [11:0] sar_q;
    logic        shut_q;
    // bus answer and output registers
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        irq_q;
    logic        wake_q;
    logic        sample_en_q;
    logic        conv_power_q;
    // synchronisers for the pins
    logic [2:0]  rc_sync_q;
    logic [1:0]  cmp_sync_q;
    logic [1:0]  slp_sync_q;

    // bus decode
    logic [9:0]  idx;
    logic        hit;
    logic        wr_ev;
    logic [7:0]  wbyte;
    logic [7:0]  rbyte;
    logic [7:0]  div_lim;
    logic        rc_edge;
    logic        tick;
    logic        sleeping;
    logic        start_ev;
    logic        abort_sw;
    logic        abort_slp;
    logic        done_ev;
    logic        decide;
    logic [3:0]  bit_pos;
    logic [11:0] sar_next;

    assign idx   = paddr[11:2];
    assign wbyte = pwdata[7:0];
    assign hit   = (idx == `ADCC_IDX_RES_LOW) || (idx == `ADCC_IDX_RES_HIGH) ||
                   (idx == `ADCC_IDX_CTRL_PRI) || (idx == `ADCC_IDX_CTRL_SEC) ||
                   (idx == `ADCC_IDX_IRQ_FLAGS) || (idx == `ADCC_IDX_IRQ_ENABLES);
    // a write lands only at the completing edge of the access phase
    assign wr_ev = psel && penable && pwrite && pready_q && hit;

    // read mux, reserved bits read zero
    always_comb begin
        rbyte = 8'h00;
        case (idx)
            `ADCC_IDX_RES_LOW:     rbyte = res_low_q;
            `ADCC_IDX_RES_HIGH:    rbyte = res_high_q;
            `ADCC_IDX_CTRL_PRI:    rbyte = {div_sel_q, chs_lo_q, go_q, en_q};
            `ADCC_IDX_CTRL_SEC:    rbyte = {align_q, chs4_q, rc_sel_q, 5'h00};
            `ADCC_IDX_IRQ_FLAGS:   rbyte = {7'h00, flag_q};
            `ADCC_IDX_IRQ_ENABLES: rbyte = {7'h00, irq_en_q};
            default:               rbyte = 8'h00;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (psel && penable && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !hit;
            prdata_q  <= pwrite ? 32'h0000_0000 : {24'h000000, rbyte};
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // pins from outside the clock domain pass two flops first
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rc_sync_q  <= 3'b000;
            cmp_sync_q <= 2'b00;
            slp_sync_q <= 2'b00;
        end else begin
            rc_sync_q  <= {rc_sync_q[1:0], rc_clk_in};
            cmp_sync_q <= {cmp_sync_q[0], cmp_high};
            slp_sync_q <= {slp_sync_q[0], sleep_req};
        end
    end

    // edge taken from the second and third stages, never the first
    assign rc_edge  = rc_sync_q[1] && !rc_sync_q[2];
    assign sleeping = slp_sync_q[1];

    // control events
    assign start_ev  = wr_ev && (idx == `ADCC_IDX_CTRL_PRI) && wbyte[`ADCC_PRI_GO] &&
                       en_q && (state_q == ADCC_ACQUIRE);
    assign abort_sw  = wr_ev && (idx == `ADCC_IDX_CTRL_PRI) && !wbyte[`ADCC_PRI_GO] &&
                       ((state_q == ADCC_CONVERT) || (state_q == ADCC_RC_DELAY));
    // leaving the fast clocks running in sleep would corrupt the result
    assign abort_slp = sleeping && !rc_sel_q && (state_q != ADCC_OFF);
    assign tick      = tad_tick_q;
    assign done_ev   = (state_q == ADCC_CONVERT) && tick &&
                       (tad_cnt_q == `ADCC_CONV_PERIODS - 5'd1);

    // divider limit from the clock select field
    always_comb begin
        case (div_sel_q)
            2'b00:   div_lim = `ADCC_DIV_CODE0;
            2'b01:   div_lim = `ADCC_DIV_CODE1;
            2'b10:   div_lim = `ADCC_DIV_CODE2;
            default: div_lim = `ADCC_DIV_CODE3;
        endcase
    end

    // bit period generator, held in reset while disabled or on a fresh start
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_q  <= 8'h00;
            tad_tick_q <= 1'b0;
        end else if (!en_q || shut_q || start_ev) begin
            div_cnt_q  <= 8'h00;
            tad_tick_q <= 1'b0;
        end else if (rc_sel_q) begin
            div_cnt_q  <= 8'h00;
            tad_tick_q <= rc_edge;
        end else if (div_cnt_q == div_lim - 8'd1) begin
            div_cnt_q  <= 8'h00;
            tad_tick_q <= 1'b1;
        end else begin
            div_cnt_q  <= div_cnt_q + 8'd1;
            tad_tick_q <= 1'b0;
        end
    end

    // successive approximation step for the current bit period
    assign decide  = (tad_cnt_q >= `ADCC_FIRST_DECIDE) &&
                     (tad_cnt_q < `ADCC_FIRST_DECIDE + 5'd12);
    assign bit_pos = 4'(5'd13 - tad_cnt_q);
    always_comb begin
        sar_next = sar_q;
        if (decide) begin
            sar_next[bit_pos] = cmp_sync_q[1];
            if (bit_pos != 4'd0) begin
                sar_next[bit_pos - 4'd1] = 1'b1;
            end
        end
    end

    // conversion sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= ADCC_ACQUIRE;
            tad_cnt_q <= 5'd0;
            dly_cnt_q <= 8'h00;
            sar_q     <= 12'h000;
        end else if (!en_q) begin
            state_q   <= ADCC_ACQUIRE;
            tad_cnt_q <= 5'd0;
        end else if (abort_slp) begin
            state_q   <= ADCC_OFF;
        end else begin
            case (state_q)
                ADCC_ACQUIRE: begin
                    if (start_ev) begin
                        state_q   <= rc_sel_q ? ADCC_RC_DELAY : ADCC_CONVERT;
                        dly_cnt_q <= 8'h00;
                        tad_cnt_q <= 5'd0;
                        sar_q     <= 12'h800;
                    end
                end
                ADCC_RC_DELAY: begin
                    if (abort_sw) begin
                        state_q   <= ADCC_RECOVER;
                        tad_cnt_q <= 5'd0;
                    end else if (dly_cnt_q == `ADCC_INSTR_CLOCKS - 8'd1) begin
                        state_q   <= ADCC_CONVERT;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 8'd1;
                    end
                end
                ADCC_CONVERT: begin
                    if (abort_sw) begin
                        state_q   <= ADCC_RECOVER;
                        tad_cnt_q <= 5'd0;
                    end else if (done_ev) begin
                        state_q   <= (sleeping && !irq_en_q) ? ADCC_OFF : ADCC_ACQUIRE;
                        tad_cnt_q <= 5'd0;
                    end else if (tick) begin
                        tad_cnt_q <= tad_cnt_q + 5'd1;
                        sar_q     <= sar_next;
                    end
                end
                ADCC_RECOVER: begin
                    if (tick && tad_cnt_q == `ADCC_ABORT_PERIODS - 5'd1) begin
                        state_q   <= ADCC_ACQUIRE;
                        tad_cnt_q <= 5'd0;
                    end else if (tick) begin
                        tad_cnt_q <= tad_cnt_q + 5'd1;
                    end
                end
                ADCC_OFF: begin
                    if (!sleeping) begin
                        state_q <= ADCC_ACQUIRE;
                    end
                end
                default: state_q <= ADCC_ACQUIRE;
            endcase
        end
    end

    // shutdown follows the off state so the divider stops with it
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shut_q <= 1'b0;
        end else begin
            shut_q <= (state_q == ADCC_OFF) && sleeping;
        end
    end

    // primary control: go is set by software, cleared by hardware
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            en_q      <= 1'b0;
            go_q      <= 1'b0;
            chs_lo_q  <= 4'h0;
            div_sel_q <= 2'b00;
        end else begin
            if (wr_ev && idx == `ADCC_IDX_CTRL_PRI) begin
                en_q      <= wbyte[`ADCC_PRI_EN];
                chs_lo_q  <= wbyte[`ADCC_PRI_CHS_LO +: 4];
                div_sel_q <= wbyte[`ADCC_PRI_DIV_LO +: 2];
            end
            // go ignored unless enable was set by an earlier write
            if (start_ev) begin
                go_q <= 1'b1;
            end else if (abort_sw || done_ev || abort_slp || !en_q) begin
                go_q <= 1'b0;
            end
        end
    end

    // secondary control
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rc_sel_q <= 1'b0;
            chs4_q   <= 1'b0;
            align_q  <= 1'b0;
        end else if (wr_ev && idx == `ADCC_IDX_CTRL_SEC) begin
            rc_sel_q <= wbyte[`ADCC_SEC_RC_SEL];
            chs4_q   <= wbyte[`ADCC_SEC_CHS4];
            align_q  <= wbyte[`ADCC_SEC_ALIGN];
        end
    end

    // done flag: a completion in the clearing cycle wins
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (done_ev) begin
                flag_q <= 1'b1;
            end else if (wr_ev && idx == `ADCC_IDX_IRQ_FLAGS) begin
                flag_q <= wbyte[0];
            end
            if (wr_ev && idx == `ADCC_IDX_IRQ_ENABLES) begin
                irq_en_q <= wbyte[0];
            end
        end
    end

    // result store, written only on completion in the chosen format
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            res_high_q <= `ADCC_RESET_VAL;
            res_low_q  <= `ADCC_RESET_VAL;
        end else if (done_ev) begin
            if (!align_q) begin
                res_high_q <= sar_next[11:4];
                res_low_q  <= {sar_next[3:0], 4'h0};
            end else begin
                res_high_q <= {6'h00, sar_next[11:10]};
                res_low_q  <= sar_next[9:2];
            end
        end
    end

    // request lines and analog controls from flops, so no pin can glitch;
    // sample follows the state one cycle late, power two cycles late through shut_q
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_q        <= 1'b0;
            wake_q       <= 1'b0;
            sample_en_q  <= 1'b0;
            conv_power_q <= 1'b0;
        end else begin
            irq_q        <= flag_q && irq_en_q;
            wake_q       <= flag_q && irq_en_q && sleeping;
            sample_en_q  <= en_q && (state_q == ADCC_ACQUIRE);
            conv_power_q <= en_q && !shut_q;
        end
    end

    // analog side, request and bus outputs
    assign chan_sel   = {chs4_q, chs_lo_q};
    assign sample_en  = sample_en_q;
    assign sar_code   = sar_q;
    assign conv_power = conv_power_q;
    assign conv_irq   = irq_q;
    assign wake_req   = wake_q;
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;

endmodule
`default_nettype wire

// ---- shared/adcc_defines.svh ----
// constants for the converter control block: offsets, fields, reset values, timing
// Overview of operation
// - selected input drives shared sample-and-hold
// - clock select sets one bit period
// - conversion lasts exactly sixteen bit periods
// - done flag set every conversion
// - done flag cleared only by software
// - flag and enable raise interrupt, wake
// - align select picks 12-bit left, 10-bit right
// - left: high bits 11..4, low 3..0
// - right: high bits 11..10, low 9..2
// - go starts conversion if already enabled
// - completion clears go, sets flag, loads result
// - clearing go aborts, results unchanged
// - abort waits two periods, then acquires
// - reset restores registers, stops conversion
// - rc clock delays start one instruction
// - sleep, irq disabled: shut down after done
// - sleep without rc clock aborts, shuts down
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
// register indices; byte address is four times the index
`define ADCC_IDX_RES_LOW     10'h09c
`define ADCC_IDX_RES_HIGH    10'h09d
`define ADCC_IDX_CTRL_PRI    10'h09e
`define ADCC_IDX_CTRL_SEC    10'h09f
`define ADCC_IDX_IRQ_FLAGS   10'h0a0
`define ADCC_IDX_IRQ_ENABLES 10'h0a1
// primary control fields
`define ADCC_PRI_EN          0
`define ADCC_PRI_GO          1
`define ADCC_PRI_CHS_LO      2
`define ADCC_PRI_DIV_LO      6
// secondary control fields
`define ADCC_SEC_RC_SEL      5
`define ADCC_SEC_CHS4        6
`define ADCC_SEC_ALIGN       7
// reset value of every register
`define ADCC_RESET_VAL       8'h00
// system clocks per bit period for each divider code
`define ADCC_DIV_CODE0       8'd8
`define ADCC_DIV_CODE1       8'd16
`define ADCC_DIV_CODE2       8'd32
`define ADCC_DIV_CODE3       8'd128
// bit periods per conversion, per abort recovery
`define ADCC_CONV_PERIODS    5'd16
`define ADCC_ABORT_PERIODS   5'd2
// first bit period that resolves a result bit
`define ADCC_FIRST_DECIDE    5'd2
// system clocks in one instruction cycle
`define ADCC_INSTR_CLOCKS    8'd4
`endif

// ---- shared/adcc_pkg.sv ----
// types shared by the converter control block
package adcc_pkg;
    typedef enum logic [2:0] {
        ADCC_ACQUIRE  = 3'b000,
        ADCC_RC_DELAY = 3'b001,
        ADCC_CONVERT  = 3'b010,
        ADCC_RECOVER  = 3'b011,
        ADCC_OFF      = 3'b100
    } adcc_state_t;
endpackage

// ---- verif/adcc_analog_model.sv ----
// behavioural sample-and-hold and comparator on the analog side
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
    input  wire logic        core_clk,
    input  wire logic [4:0]  chan_sel,
    input  wire logic        sample_en,
    input  wire logic        conv_power,
    input  wire logic [11:0] sar_code,
    output logic             cmp_high
);
    logic [11:0] hold_q;
    logic        tog_q = 1'b0;
    // each input carries a level derived from its number; frozen while converting
    always_ff @(posedge core_clk) begin
        tog_q <= !tog_q;
        if (sample_en)
            hold_q <= {chan_sel, ~chan_sel, 2'b10};
    end
    // high when the held level is at or above the code; unpowered it gives a changing pattern
    assign cmp_high = conv_power ? (hold_q >= sar_code) : tog_q;
endmodule
`default_nettype wire

// ---- verif/adcc_assertions.sv ----
// port checks for the converter control block
`timescale 1ns/1ps
`include "adcc_defines.svh"
`default_nettype none
module adcc_assertions (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        sleep_req,
    input wire logic [4:0]  chan_sel,
    input wire logic        sample_en,
    input wire logic        conv_power,
    input wire logic        conv_irq
);
    logic       en_q, rc_q, ie_q, busy_q, abt_q, se_q;
    logic [1:0] div_q;
    logic [7:0] cnt_q;
    wire logic [9:0] idx = paddr[11:2];
    wire logic  wr = psel && penable && pready && pwrite;
    wire logic  wr_pri = wr && idx == `ADCC_IDX_CTRL_PRI;
    wire logic  wr_irq = wr && (idx == `ADCC_IDX_IRQ_FLAGS || idx == `ADCC_IDX_IRQ_ENABLES);
    wire logic  start = wr_pri && pwdata[1] && en_q && sample_en;
    wire logic  stop = wr_pri && !pwdata[1] && busy_q;
    // shadow of control fields and cycles since a start or an abort
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            {en_q, div_q, rc_q, ie_q} <= '0;
            {busy_q, abt_q, se_q} <= '0;
            cnt_q <= '0;
        end else begin
            se_q <= sample_en;
            cnt_q <= (start || stop) ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
            if (wr_pri)
                {div_q, en_q} <= {pwdata[7:6], pwdata[0]};
            if (wr && idx == `ADCC_IDX_CTRL_SEC)
                rc_q <= pwdata[5];
            if (wr && idx == `ADCC_IDX_IRQ_ENABLES)
                ie_q <= pwdata[0];
            if (start)
                busy_q <= 1'b1;
            else if ((sample_en && !se_q) || !conv_power)
                busy_q <= 1'b0;
            if (start)
                abt_q <= 1'b0;
            else if (stop)
                abt_q <= 1'b1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_chan_follows: assert property (wr_pri |=> chan_sel[3:0] == $past(pwdata[5:2]))
        else $error("channel select did not follow the write");
    a_conv_length: assert property ($rose(sample_en) && busy_q && !abt_q && div_q == 2'b00
        && !rc_q |-> cnt_q inside {[8'd125:8'd131]}) else $error("conversion length wrong");
    a_abort_recover: assert property ($rose(sample_en) && abt_q && !rc_q
        && div_q == 2'b00 |-> cnt_q inside {[8'd8:8'd19]}) else $error("abort recovery wrong");
    a_irq_needs_en: assert property (conv_irq |-> ie_q || $past(ie_q))
        else $error("interrupt without enable");
    a_flag_sticky: assert property ($fell(conv_irq)
        |-> $past(wr_irq) || $past(wr_irq, 2) || $past(wr_irq, 3))
        else $error("flag self cleared");
    a_enable_off: assert property (wr_pri && !pwdata[0] |-> ##[1:3] !conv_power)
        else $error("converter still powered after disable");
    a_reset_quiet: assert property ($rose(rstn) |-> !conv_power && !sample_en
        && chan_sel == 5'h00 && !conv_irq) else $error("outputs not cleared by reset");
    a_sleep_abort: assert property ($rose(sleep_req) && !rc_q |-> ##[1:6] !conv_power)
        else $error("sleep did not shut converter down");
    c_start: cover property (start);
    c_abort: cover property (stop);
    c_irq: cover property ($rose(conv_irq));
endmodule
bind adcc_conversion_control adcc_assertions adcc_assertions_inst (.core_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .sleep_req, .chan_sel, .sample_en,
    .conv_power, .conv_irq);
`default_nettype wire

// ---- verif/adcc_conversion_control_tb_top.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adcc_defines.svh"
`default_nettype none
module adcc_conversion_control_tb_top;
    typedef struct packed {
        logic [1:0] div;
        logic       al;
        logic [4:0] ch;
        logic [7:0] hi;
        logic [7:0] lo;
    } adcc_row_t;
    adcc_row_t   rows [4] = '{'{2'd0, 1'b0, 5'h01, 8'h0f, 8'ha0},
                          '{2'd1, 1'b1, 5'h0b, 8'h01, 8'h74},
                          '{2'd2, 1'b0, 5'h10, 8'h83, 8'he0},
                          '{2'd3, 1'b1, 5'h12, 8'h02, 8'h4d}};
    int          per [4] = '{`ADCC_DIV_CODE0, `ADCC_DIV_CODE1,
                             `ADCC_DIV_CODE2, `ADCC_DIV_CODE3};
    logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        sleep_req = 1'b0, rc_clk_in = 1'b0, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    wire  [31:0] prdata;
    wire  [11:0] sar_code;
    wire  [4:0]  chan_sel;
    wire         pready, pslverr, cmp_high, sample_en, conv_power, conv_irq, wake_req;
    int          failures = 0, compares = 0, cyc = 0, el, n;
    // core clock, a free-running rc clock of unrelated phase, and a cycle count
    always #20 core_clk = !core_clk;
    always #185 rc_clk_in = !rc_clk_in;
    always @(posedge core_clk) cyc <= cyc + 1;
    adcc_conversion_control adcc_conversion_control_inst (.core_clk, .rstn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_req, .rc_clk_in,
        .cmp_high, .chan_sel, .sample_en, .sar_code, .conv_power, .conv_irq, .wake_req);
    adcc_analog_model adcc_analog_model_inst (.core_clk, .chan_sel, .sample_en, .conv_power,
        .sar_code, .cmp_high);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conv_wait(output int e);
        int t0;
        t0 = cyc;
        do apb(0, `ADCC_IDX_CTRL_PRI, 8'h00);
        while (rd[1] === 1'b1 && cyc - t0 < 4000);
        e = cyc - t0;
    endtask
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog well beyond the expected run of some 4200 cycles
    initial begin
        #2ms;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        for (int a = 'h9c; a <= 'ha1; a++) begin
            apb(0, a[9:0], 8'h00);
            check(rd, 32'h0);
        end
        apb(0, 10'h0a2, 8'h00);
        check(err, 1'b1);
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h03);
        apb(0, `ADCC_IDX_CTRL_PRI, 8'h00);
        check(rd[1], 1'b0);
        // ordinary conversions: each clock divider, both alignments
        foreach (rows[i]) begin
            apb(1, `ADCC_IDX_CTRL_SEC, {rows[i].al, rows[i].ch[4], 6'h00});
            apb(1, `ADCC_IDX_CTRL_PRI, {rows[i].div, rows[i].ch[3:0], 2'b01});
            repeat (40) @(posedge core_clk); // settling and acquisition
            check(chan_sel, rows[i].ch);
            apb(1, `ADCC_IDX_CTRL_PRI, {rows[i].div, rows[i].ch[3:0], 2'b11});
            conv_wait(el);
            n = `ADCC_CONV_PERIODS * per[rows[i].div];
            check(el >= n && el <= n + 12, 1'b1);
            apb(0, `ADCC_IDX_RES_HIGH, 8'h00);
            check(rd, rows[i].hi);
            apb(0, `ADCC_IDX_RES_LOW, 8'h00);
            check(rd, rows[i].lo);
            apb(0, `ADCC_IDX_IRQ_FLAGS, 8'h00);
            check(rd, 32'h1);
            apb(1, `ADCC_IDX_IRQ_FLAGS, 8'h00);
        end
        // abort, then disable, each in mid-conversion; results must survive
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h03);
        repeat (40) @(posedge core_clk);
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h01);
        apb(0, `ADCC_IDX_RES_HIGH, 8'h00);
        check(rd, rows[3].hi);
        repeat (30) @(posedge core_clk);
        check(sample_en, 1'b1);
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h03);
        repeat (30) @(posedge core_clk);
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h00);
        apb(0, `ADCC_IDX_CTRL_PRI, 8'h00);
        check(rd, 32'h0);
        check(conv_power, 1'b0);
        apb(0, `ADCC_IDX_RES_LOW, 8'h00);
        check(rd, rows[3].lo);
        // rc clock in sleep: interrupt wakes, then with it disabled the converter stops
        for (int ie = 1; ie >= 0; ie--) begin
            apb(1, `ADCC_IDX_IRQ_ENABLES, ie[7:0]);
            apb(1, `ADCC_IDX_CTRL_SEC, 8'h20);
            apb(1, `ADCC_IDX_CTRL_PRI, 8'h01);
            repeat (40) @(posedge core_clk);
            apb(1, `ADCC_IDX_CTRL_PRI, 8'h03);
            sleep_req <= 1'b1;
            for (n = 0; n < 1000 && (conv_irq !== ie[0] || conv_power !== ie[0]); n++)
                @(posedge core_clk);
            repeat (60) @(posedge core_clk);
            check(conv_irq, ie[0]);
            check(wake_req, ie[0]);
            check(conv_power, ie[0]);
            sleep_req <= 1'b0;
            apb(1, `ADCC_IDX_IRQ_FLAGS, 8'h00);
            repeat (4) @(posedge core_clk);
            check(conv_irq, 1'b0);
        end
        // sleep on the divided clock aborts at once
        apb(1, `ADCC_IDX_CTRL_SEC, 8'h00);
        repeat (40) @(posedge core_clk);
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h03);
        repeat (20) @(posedge core_clk);
        sleep_req <= 1'b1;
        repeat (8) @(posedge core_clk);
        check(conv_power, 1'b0);
        sleep_req <= 1'b0;
        repeat (40) @(posedge core_clk);
        // reset in mid-conversion
        apb(1, `ADCC_IDX_CTRL_PRI, 8'h03);
        repeat (20) @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({conv_power, sample_en, chan_sel}, 7'h00);
        rstn <= 1'b1;
        apb(0, `ADCC_IDX_CTRL_PRI, 8'h00);
        check(rd, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
